// ===== rtl/wcr_defs.svh
// register offsets, field positions and reset values of the window comparator bank
`ifndef WCR_DEFS_SVH
`define WCR_DEFS_SVH
`define WCR_OFS_LOW_FLAGS 8'h0C
`define WCR_OFS_HIGH_FLAGS 8'h0E
`define WCR_OFS_ALERT_EN 8'h34
`define WCR_OFS_QUAL_CNT 8'h36
`define WCR_OFS_CMP_EN 8'h37
`define WCR_OFS_C0_UP_LO 8'h38
`define WCR_OFS_C0_UP_HI 8'h39
`define WCR_OFS_C0_LW_LO 8'h3A
`define WCR_OFS_C0_LW_HI 8'h3B
`define WCR_OFS_C1_UP_LO 8'h3C
`define WCR_OFS_C1_UP_HI 8'h3D
`define WCR_OFS_C1_LW_LO 8'h3E
`define WCR_OFS_C1_LW_HI 8'h3F
`define WCR_OFS_C0_HYS 8'h40
`define WCR_OFS_C1_HYS 8'h41
`define WCR_QUAL_LSB 4
`define WCR_RST_BYTE 8'h00
`define WCR_RST_ALERT_EN 2'h0
`define WCR_RST_NIB 4'h0
`define WCR_RST_HYS 6'h00
`define WCR_RST_CNT 5'h00
`endif

// ===== rtl/wcr_pkg.sv
// types of the window comparator register bank
package wcr_pkg;
   typedef struct packed {
      logic [11:0] upper;
      logic [11:0] lower;
      logic [5:0] hys;
   } wcr_limits_t;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wcr_wr_t;
   typedef enum logic [1:0] {
      WCR_ST_CLEAR = 2'b00,
      WCR_ST_COUNT = 2'b01,
      WCR_ST_ALERT = 2'b10
   } wcr_side_st_t;
endpackage

// ===== rtl/wcr_regs.sv
// window comparator configuration bank with two-channel alert datapath
`include "wcr_defs.svh"
module wcr_regs
   import wcr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire wcr_wr_t reg_wr,
   input wire logic [7:0] reg_raddr,
   output logic [7:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic sample_chan,
   input wire logic [11:0] sample_data,
   output logic [1:0] over_flags,
   output logic [1:0] under_flags,
   output logic alert
);
   logic [1:0] alert_en_q, alert_en_d;
   logic cmp_en_q, cmp_en_d;
   logic [3:0] qual_q, qual_d;
   wcr_limits_t lim_q [2];
   wcr_limits_t lim_d [2];
   logic [7:0] rdata_d;
   logic [1:0] over_clr, under_clr;
   logic [1:0] beyond_hi, beyond_lo, rel_hi, rel_lo, ch_active, ch_valid;
   always_comb begin
      alert_en_d = alert_en_q;
      cmp_en_d = cmp_en_q;
      qual_d = qual_q;
      lim_d = lim_q;
      over_clr = 2'b00;
      under_clr = 2'b00;
      if (reg_wr.wr) begin
         // bits outside each field are simply not stored
         case (reg_wr.addr)
            `WCR_OFS_ALERT_EN: alert_en_d = reg_wr.wdata[1:0];
            `WCR_OFS_CMP_EN: cmp_en_d = reg_wr.wdata[0];
            `WCR_OFS_QUAL_CNT: qual_d = reg_wr.wdata[`WCR_QUAL_LSB +: 4];
            `WCR_OFS_LOW_FLAGS: under_clr = reg_wr.wdata[1:0];
            `WCR_OFS_HIGH_FLAGS: over_clr = reg_wr.wdata[1:0];
            `WCR_OFS_C0_UP_LO: lim_d[0].upper[7:0] = reg_wr.wdata;
            `WCR_OFS_C0_UP_HI: lim_d[0].upper[11:8] = reg_wr.wdata[3:0];
            `WCR_OFS_C0_LW_LO: lim_d[0].lower[7:0] = reg_wr.wdata;
            `WCR_OFS_C0_LW_HI: lim_d[0].lower[11:8] = reg_wr.wdata[3:0];
            `WCR_OFS_C1_UP_LO: lim_d[1].upper[7:0] = reg_wr.wdata;
            `WCR_OFS_C1_UP_HI: lim_d[1].upper[11:8] = reg_wr.wdata[3:0];
            `WCR_OFS_C1_LW_LO: lim_d[1].lower[7:0] = reg_wr.wdata;
            `WCR_OFS_C1_LW_HI: lim_d[1].lower[11:8] = reg_wr.wdata[3:0];
            `WCR_OFS_C0_HYS: lim_d[0].hys = reg_wr.wdata[5:0];
            `WCR_OFS_C1_HYS: lim_d[1].hys = reg_wr.wdata[5:0];
            default: ;
         endcase
      end
      // unmapped reads return zero
      case (reg_raddr)
         `WCR_OFS_ALERT_EN: rdata_d = {6'h00, alert_en_q};
         `WCR_OFS_CMP_EN: rdata_d = {7'h00, cmp_en_q};
         `WCR_OFS_QUAL_CNT: rdata_d = {qual_q, 4'h0};
         `WCR_OFS_LOW_FLAGS: rdata_d = {6'h00, under_flags};
         `WCR_OFS_HIGH_FLAGS: rdata_d = {6'h00, over_flags};
         `WCR_OFS_C0_UP_LO: rdata_d = lim_q[0].upper[7:0];
         `WCR_OFS_C0_UP_HI: rdata_d = {4'h0, lim_q[0].upper[11:8]};
         `WCR_OFS_C0_LW_LO: rdata_d = lim_q[0].lower[7:0];
         `WCR_OFS_C0_LW_HI: rdata_d = {4'h0, lim_q[0].lower[11:8]};
         `WCR_OFS_C1_UP_LO: rdata_d = lim_q[1].upper[7:0];
         `WCR_OFS_C1_UP_HI: rdata_d = {4'h0, lim_q[1].upper[11:8]};
         `WCR_OFS_C1_LW_LO: rdata_d = lim_q[1].lower[7:0];
         `WCR_OFS_C1_LW_HI: rdata_d = {4'h0, lim_q[1].lower[11:8]};
         `WCR_OFS_C0_HYS: rdata_d = {2'h0, lim_q[0].hys};
         `WCR_OFS_C1_HYS: rdata_d = {2'h0, lim_q[1].hys};
         default: rdata_d = `WCR_RST_BYTE;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         alert_en_q <= `WCR_RST_ALERT_EN;
         cmp_en_q <= 1'b0;
         qual_q <= `WCR_RST_NIB;
         for (int i = 0; i < 2; i++) begin
            lim_q[i] <= '0;
         end
         reg_rdata <= `WCR_RST_BYTE;
      end else begin
         alert_en_q <= alert_en_d;
         cmp_en_q <= cmp_en_d;
         qual_q <= qual_d;
         lim_q <= lim_d;
         reg_rdata <= rdata_d;
      end
   end
   // release points widened to 13 bits so the band never wraps
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         ch_active[c] = cmp_en_q & alert_en_q[c];
         ch_valid[c] = sample_valid & (sample_chan == c[0]);
         beyond_hi[c] = sample_data > lim_q[c].upper;
         beyond_lo[c] = sample_data < lim_q[c].lower;
         rel_hi[c] = {1'b0, sample_data} + {7'h00, lim_q[c].hys} <= {1'b0, lim_q[c].upper};
         rel_lo[c] = {1'b0, sample_data} >= {1'b0, lim_q[c].lower} + {7'h00, lim_q[c].hys};
      end
   end
   for (genvar g = 0; g < 2; g++) begin : g_ch
      wcr_side_cmp u_hi (
         .clk_sys(clk_sys),
         .rst(rst),
         .active(ch_active[g]),
         .sample_valid(ch_valid[g]),
         .beyond(beyond_hi[g]),
         .released(rel_hi[g]),
         .qual_cnt(qual_q),
         .flag_clr(over_clr[g]),
         .flag_q(over_flags[g])
      );
      wcr_side_cmp u_lo (
         .clk_sys(clk_sys),
         .rst(rst),
         .active(ch_active[g]),
         .sample_valid(ch_valid[g]),
         .beyond(beyond_lo[g]),
         .released(rel_lo[g]),
         .qual_cnt(qual_q),
         .flag_clr(under_clr[g]),
         .flag_q(under_flags[g])
      );
   end
   assign alert = |over_flags | |under_flags;

   a_rdata_reserved: assert property (@(posedge clk_sys) disable iff (rst)
      $past(reg_raddr) == `WCR_OFS_C0_HYS |-> reg_rdata[7:6] == 2'b00)
      else $error("hysteresis reserved bits read nonzero");
   a_rdata_nibble: assert property (@(posedge clk_sys) disable iff (rst)
      $past(reg_raddr) == `WCR_OFS_C1_LW_HI |-> reg_rdata[7:4] == 4'h0)
      else $error("limit top register reserved bits read nonzero");
   a_rdata_byte: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(rst) && $past(reg_raddr) == `WCR_OFS_C0_UP_LO |-> reg_rdata == $past(lim_q[0].upper[7:0]))
      else $error("upper limit bottom bits read back wrong");
   a_limit_write: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C0_UP_HI |=> lim_q[0].upper[11:8] == $past(reg_wr.wdata[3:0]))
      else $error("upper limit top bits not stored");
   a_limit_bottom: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C0_UP_LO |=> lim_q[0].upper[7:0] == $past(reg_wr.wdata))
      else $error("upper limit bottom bits not stored");
   a_lower_top: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C0_LW_HI |=> lim_q[0].lower[11:8] == $past(reg_wr.wdata[3:0]))
      else $error("lower limit top bits not stored");
   a_lower_bottom: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C0_LW_LO |=> lim_q[0].lower[7:0] == $past(reg_wr.wdata))
      else $error("lower limit bottom bits not stored");
   a_c1_upper: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C1_UP_HI |=> lim_q[1].upper[11:8] == $past(reg_wr.wdata[3:0]))
      else $error("second channel upper top bits not stored");
   a_c1_upper_low: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C1_UP_LO |=> lim_q[1].upper[7:0] == $past(reg_wr.wdata))
      else $error("second channel upper bottom bits not stored");
   a_low_write: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C1_LW_LO |=> lim_q[1].lower[7:0] == $past(reg_wr.wdata))
      else $error("lower limit bottom bits not stored");
   a_c1_lower_top: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C1_LW_HI |=> lim_q[1].lower[11:8] == $past(reg_wr.wdata[3:0]))
      else $error("second channel lower top bits not stored");
   a_hys_c0: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C0_HYS |=> lim_q[0].hys == $past(reg_wr.wdata[5:0]))
      else $error("first channel hysteresis not stored");
   a_hys_write: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_C1_HYS |=> lim_q[1].hys == $past(reg_wr.wdata[5:0]))
      else $error("hysteresis not stored");
   a_en_write: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_ALERT_EN |=> alert_en_q == $past(reg_wr.wdata[1:0]))
      else $error("alert enables not stored");
   a_cmp_write: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_CMP_EN |=> cmp_en_q == $past(reg_wr.wdata[0]))
      else $error("comparator enable not stored");
   a_qual_write: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_QUAL_CNT |=> qual_q == $past(reg_wr.wdata[`WCR_QUAL_LSB +: 4]))
      else $error("qualify count not stored");
   a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      !alert_en_q[0] ##1 !alert_en_q[0] |-> !$rose(over_flags[0]) && !$rose(under_flags[0]))
      else $error("flag set on disabled channel");
   a_block_off: assert property (@(posedge clk_sys) disable iff (rst)
      !cmp_en_q ##1 !cmp_en_q |-> !$rose(over_flags[1]) && !$rose(under_flags[1]))
      else $error("flag set while comparator off");
   a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_HIGH_FLAGS && reg_wr.wdata[0] && over_flags[0]
      |=> !over_flags[0] || $past(ch_valid[0] && beyond_hi[0]))
      else $error("over flag not cleared");
   a_under_clear: assert property (@(posedge clk_sys) disable iff (rst)
      reg_wr.wr && reg_wr.addr == `WCR_OFS_LOW_FLAGS && reg_wr.wdata[1] && under_flags[1]
      |=> !under_flags[1] || $past(ch_valid[1] && beyond_lo[1]))
      else $error("under flag not cleared");
   // a side still latched past its limit waits for release, so it is excluded
   a_first_hit: assert property (@(posedge clk_sys) disable iff (rst)
      qual_q == 4'h0 && ch_active[0] && ch_valid[0] && beyond_hi[0] && !over_flags[0]
      && g_ch[0].u_hi.st_q != WCR_ST_ALERT
      && !(reg_wr.wr && reg_wr.addr == `WCR_OFS_CMP_EN) |=> over_flags[0])
      else $error("single event did not raise flag");
   a_over_cause: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(over_flags[0]) |-> $past(ch_active[0] && ch_valid[0] && beyond_hi[0]))
      else $error("over flag rose without an event above the limit");
   a_under_cause: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(under_flags[1]) |-> $past(ch_active[1] && ch_valid[1] && beyond_lo[1]))
      else $error("under flag rose without an event below the limit");
   a_en_reset: assert property (@(posedge clk_sys) $past(rst) |-> alert_en_q == 2'b00)
      else $error("alert enables not zero after reset");
   c_over_ch0: cover property (@(posedge clk_sys) disable iff (rst) $rose(over_flags[0]));
   c_under_ch1: cover property (@(posedge clk_sys) disable iff (rst) $rose(under_flags[1]));
   c_clear: cover property (@(posedge clk_sys) disable iff (rst) $fell(over_flags[0]));
   c_rearm: cover property (@(posedge clk_sys) disable iff (rst)
      g_ch[0].u_hi.st_q == WCR_ST_ALERT && ch_valid[0] && rel_hi[0]);
   c_single_event: cover property (@(posedge clk_sys) disable iff (rst) qual_q == 4'h0 && $rose(over_flags[0]));
endmodule

// ===== rtl/wcr_side_cmp.sv
// one comparator side: qualify count, latched flag, hysteresis release
`include "wcr_defs.svh"
module wcr_side_cmp
   import wcr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic active,
   input wire logic sample_valid,
   input wire logic beyond,
   input wire logic released,
   input wire logic [3:0] qual_cnt,
   input wire logic flag_clr,
   output logic flag_q
);
   wcr_side_st_t st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic flag_d;
   logic hit;
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      hit = 1'b0;
      case (st_q)
         WCR_ST_CLEAR, WCR_ST_COUNT: begin
            if (!active) begin
               st_d = WCR_ST_CLEAR;
               cnt_d = `WCR_RST_CNT;
            end else if (sample_valid) begin
               if (beyond) begin
                  // alert after count plus one consecutive events
                  if (cnt_q >= {1'b0, qual_cnt}) begin
                     hit = 1'b1;
                     st_d = WCR_ST_ALERT;
                     cnt_d = `WCR_RST_CNT;
                  end else begin
                     st_d = WCR_ST_COUNT;
                     cnt_d = cnt_q + 5'h01;
                  end
               end else begin
                  st_d = WCR_ST_CLEAR;
                  cnt_d = `WCR_RST_CNT;
               end
            end
         end
         WCR_ST_ALERT: begin
            // comparator re-arms past the hysteresis band or when the side goes inactive
            if (!active || (sample_valid && released))
               st_d = WCR_ST_CLEAR;
         end
         default: begin
            st_d = WCR_ST_CLEAR;
            cnt_d = `WCR_RST_CNT;
         end
      endcase
      // set wins over a clear in the same cycle
      flag_d = hit | (flag_q & ~flag_clr);
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= WCR_ST_CLEAR;
         cnt_q <= `WCR_RST_CNT;
         flag_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         flag_q <= flag_d;
      end
   end
endmodule

// ===== verif/wcr_host.sv
// host-side model driving the bank's parallel register port
module wcr_host
   import wcr_pkg::*;
(
   input wire logic clk_sys,
   output wcr_wr_t reg_wr,
   output logic [7:0] reg_raddr,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr = '0;
      reg_raddr = 8'h00;
   end
   // one-cycle strobe; released fields flip so stale values never look valid
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_wr = '{wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_sys);
      #1;
      reg_wr = '{wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // read data is registered, so it is taken one edge after the address
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_raddr = a;
      @(posedge clk_sys);
      #1;
      d = reg_rdata;
   endtask
endmodule

// ===== verif/wcr_regs_tb.sv
// self-checking bench for the window comparator register bank
module wcr_regs_tb;
   import wcr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys;
   logic rst;
   wcr_wr_t reg_wr;
   logic [7:0] reg_raddr;
   logic [7:0] reg_rdata;
   logic sample_valid;
   logic sample_chan;
   logic [11:0] sample_data;
   logic [1:0] over_flags;
   logic [1:0] under_flags;
   logic alert;
   int errors;
   int n_tests;
   logic [7:0] rd;
   // last entry is unmapped; flag registers clear on write so read back zero
   logic [7:0] ofs [16] = '{8'h34, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C,
                            8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h0C, 8'h0E, 8'h50};
   logic [7:0] msk [16] = '{8'h03, 8'hF0, 8'h01, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF,
                            8'h0F, 8'hFF, 8'h0F, 8'h3F, 8'h3F, 8'h00, 8'h00, 8'h00};
   wcr_regs i_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_raddr(reg_raddr),
      .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_chan(sample_chan),
      .sample_data(sample_data), .over_flags(over_flags), .under_flags(under_flags), .alert(alert));
   wcr_host i_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.write_reg(a, d);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
      i_host.read_reg(a, rd);
      chk(nm, e, rd);
   endtask
   // one sample pulse; the flag lands on the edge that takes it
   task automatic samp(input logic ch, input logic [11:0] d);
      @(posedge clk_sys);
      #1;
      sample_valid = 1'b1;
      sample_chan = ch;
      sample_data = d;
      @(posedge clk_sys);
      #1;
      sample_valid = 1'b0;
      sample_data = ~d;
   endtask
   task automatic fchk(input logic [1:0] o, input logic [1:0] u);
      chk("flags", {3'h0, |{o, u}, o, u}, {3'h0, alert, over_flags, under_flags});
   endtask
   initial begin
      #400000;
      errors++;
      close_out();
   end
   initial begin
      errors = 0;
      n_tests = 0;
      rst = 1'b1;
      sample_valid = 1'b0;
      sample_chan = 1'b0;
      sample_data = 12'h000;
      repeat (20) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         rdc("reset", ofs[i], 8'h00);
      end
      for (int i = 0; i < 16; i++) begin
         wr(ofs[i], 8'hFF);
         rdc("ones", ofs[i], msk[i]);
         wr(ofs[i], 8'h5A);
         rdc("pattern", ofs[i], 8'h5A & msk[i]);
      end
      // second reset in mid-run
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      rdc("rerun", 8'h34, 8'h00);
      wr(8'h39, 8'h01);
      wr(8'h38, 8'h23);
      wr(8'h3A, 8'h45);
      wr(8'h3D, 8'h0F);
      wr(8'h3C, 8'hFF);
      wr(8'h3E, 8'h80);
      wr(8'h40, 8'h04);
      wr(8'h36, 8'h10);
      wr(8'h34, 8'h01);
      wr(8'h37, 8'h01);
      samp(1'b0, 12'h123);
      samp(1'b0, 12'h123);
      fchk(2'b00, 2'b00);
      samp(1'b0, 12'h124);
      fchk(2'b00, 2'b00);
      samp(1'b0, 12'h124);
      fchk(2'b01, 2'b00);
      rdc("high", 8'h0E, 8'h01);
      samp(1'b1, 12'h07F);
      samp(1'b1, 12'h07F);
      fchk(2'b01, 2'b00);
      wr(8'h34, 8'h03);
      samp(1'b1, 12'h07F);
      samp(1'b1, 12'h07F);
      fchk(2'b01, 2'b10);
      rdc("low", 8'h0C, 8'h02);
      wr(8'h0E, 8'h01);
      fchk(2'b00, 2'b10);
      // no new alert until the sample leaves the hysteresis band
      samp(1'b0, 12'h124);
      samp(1'b0, 12'h124);
      fchk(2'b00, 2'b10);
      samp(1'b0, 12'h120);
      samp(1'b0, 12'h124);
      samp(1'b0, 12'h124);
      fchk(2'b00, 2'b10);
      samp(1'b0, 12'h11F);
      samp(1'b0, 12'h124);
      samp(1'b0, 12'h124);
      fchk(2'b01, 2'b10);
      wr(8'h0E, 8'h01);
      wr(8'h0C, 8'h01);
      fchk(2'b00, 2'b10);
      wr(8'h0C, 8'h02);
      fchk(2'b00, 2'b00);
      wr(8'h37, 8'h00);
      samp(1'b0, 12'h044);
      samp(1'b0, 12'h044);
      fchk(2'b00, 2'b00);
      wr(8'h37, 8'h01);
      samp(1'b0, 12'h045);
      samp(1'b0, 12'h045);
      fchk(2'b00, 2'b00);
      samp(1'b0, 12'h044);
      samp(1'b0, 12'h044);
      fchk(2'b00, 2'b01);
      // zero qualify count: a single event is enough
      wr(8'h36, 8'h00);
      samp(1'b0, 12'h124);
      fchk(2'b01, 2'b01);
      close_out();
   end
endmodule
